// file: pkg/imrcal_pkg.sv
package imrcal_pkg;

   // ********************************************************
   // register map, byte addresses
   // ********************************************************
   localparam int          ADDR_W    = 8;
   localparam logic [7:0]  OFS_TRIM  = 8'h00;
   localparam logic [7:0]  OFS_GAIN  = 8'h04;
   localparam logic [7:0]  OFS_CLK   = 8'h08;
   localparam logic [7:0]  OFS_DEMOD = 8'h0c;
   localparam logic [7:0]  OFS_TONE  = 8'h10;
   localparam logic [7:0]  OFS_RSSI  = 8'h14;

   // ********************************************************
   // reset values
   // ********************************************************
   localparam logic [31:0] RST_TRIM  = 32'h0000_0000;
   localparam logic [31:0] RST_GAIN  = 32'h0000_0000;
   localparam logic [31:0] RST_CLK   = 32'h0000_0000;
   localparam logic [31:0] RST_DEMOD = 32'h0000_0000;
   localparam logic        RST_HALF  = 1'b0;

   // ********************************************************
   // field positions
   // ********************************************************
   localparam int TRIM_POL_BIT   = 31;
   localparam int TRIM_GSIDE_BIT = 30;
   localparam int TRIM_GLVL_LSB  = 25;
   localparam int TRIM_PSIDE_BIT = 24;
   localparam int TRIM_PLVL_LSB  = 20;
   localparam int TRIM_COARSE_BIT = 4;
   localparam int GSEL_LSB       = 18;
   localparam int FAMP_GAIN_LSB  = 20;
   localparam int FILT_GAIN_LSB  = 22;
   localparam int FAMP_BIAS_LSB  = 26;
   localparam int DIV_LSB        = 6;
   localparam int BW_LSB         = 30;
   localparam int TONE_HALF_BIT  = 0;
   localparam int RSSI_VALID_BIT = 8;

   // ********************************************************
   // data path constants
   // ********************************************************
   localparam int          SAMPLE_W  = 12;
   localparam logic [6:0]  RSSI_MAX  = 7'h50;
   localparam logic [6:0]  UNITY     = 7'h20;

   typedef struct packed {
      logic       gain_atten;
      logic       gain_on_q;
      logic [4:0] gain_level;
      logic       phase_on_q;
      logic [3:0] phase_level;
   } imrcal_trim_s;

   typedef struct packed {
      logic signed [SAMPLE_W-1:0] i;
      logic signed [SAMPLE_W-1:0] q;
   } imrcal_iq_s;

endpackage

// file: rtl/imrcal_iq_trim.sv
`timescale 1ns/1ns
module imrcal_iq_trim (
   input  wire logic                clk,          // system clock
   input  wire logic                sys_rst,      // sync reset, high
   input  wire imrcal_pkg::imrcal_trim_s trim,    // decoded trim settings
   input  wire imrcal_pkg::imrcal_iq_s   in_iq,   // mixer samples
   input  wire logic                in_valid,     // sample strobe
   output imrcal_pkg::imrcal_iq_s   out_iq_ff,    // corrected samples
   output logic                     out_valid_ff  // corrected strobe
);

   localparam int SW = imrcal_pkg::SAMPLE_W;

   // ********************************************************
   // scaling helper, factor in 1/32 units
   // ********************************************************
   function automatic logic signed [SW-1:0] scale(input logic signed [SW-1:0] x,
                                                  input logic [6:0] k);
      logic signed [SW+7:0] p;
      p = x * $signed({1'b0, k});
      // keep low bits on purpose: overflow wraps like the analog trim
      return p[SW+4:5];
   endfunction

   logic [4:0]          eff_level;
   logic [6:0]          gain_k;
   logic signed [SW-1:0] gi;
   logic signed [SW-1:0] gq;
   logic signed [SW-1:0] pi_x;
   logic signed [SW-1:0] pq_x;
   imrcal_pkg::imrcal_iq_s nxt_out;

   // ********************************************************
   // gain and phase trim
   // ********************************************************
   always_comb begin
      // attenuation honours only the low four level bits
      eff_level = trim.gain_atten ? {1'b0, trim.gain_level[3:0]} : trim.gain_level;
      gain_k    = trim.gain_atten ? 7'(imrcal_pkg::UNITY - {2'b00, eff_level})
                                  : 7'(imrcal_pkg::UNITY + {2'b00, eff_level});
      gi = trim.gain_on_q ? in_iq.i : scale(in_iq.i, gain_k);
      gq = trim.gain_on_q ? scale(in_iq.q, gain_k) : in_iq.q;
      pi_x = scale(gq, {3'b000, trim.phase_level}) >>> 1;
      pq_x = scale(gi, {3'b000, trim.phase_level}) >>> 1;
      nxt_out.i = trim.phase_on_q ? gi : SW'(gi + pi_x);
      nxt_out.q = trim.phase_on_q ? SW'(gq + pq_x) : gq;
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         out_iq_ff    <= '0;
         out_valid_ff <= 1'b0;
      end else begin
         out_valid_ff <= in_valid;
         if (in_valid) begin
            out_iq_ff <= nxt_out;
         end
      end
   end

endmodule // imrcal_iq_trim

// file: rtl/imrcal_top.sv
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - gain trim level bits 25-29; attenuation uses four bits, levels 0-15.
// - amplifying uses all five bits, levels 0-31, results wrap around.
// - bit 24 steers phase trim: 0 in-phase path, 1 quadrature path.
// - bits 20-23 hold the phase trim level.
// - tone base clock is clock divided by divider bits 6-9; keep small.
// - signal strength readback spans 0 weak to 80 strong, raw code.
// - bit 31 picks gain or attenuation; keep at 1, attenuation.
// - bit 30 steers gain trim: 0 in-phase path, 1 quadrature path.
module imrcal_top #(
   parameter int AVG_LOG2 = 6                      // log2 of strength window
) (
   input  wire logic                         clk,              // system clock
   input  wire logic                         sys_rst,          // sync reset, high
   input  wire logic [imrcal_pkg::ADDR_W-1:0] reg_addr,        // register address
   input  wire logic [31:0]                  reg_wdata,        // write data
   input  wire logic                         reg_wr,           // write strobe
   input  wire logic                         reg_rd,           // read strobe
   output logic [31:0]                       reg_rdata_ff,     // read data, next cycle
   input  wire imrcal_pkg::imrcal_iq_s       adc_iq,           // raw mixer samples
   input  wire logic                         adc_valid,        // sample strobe
   output imrcal_pkg::imrcal_iq_s            trim_iq_ff,       // corrected samples
   output logic                              trim_valid_ff,    // corrected strobe
   output logic                              tone_tick_ff,     // internal tone pulse
   output logic                              coarse_cal_ff,    // coarse cal start pulse
   output logic [1:0]                        gain_ctl_sel_ff,  // gain control select
   output logic [1:0]                        front_amp_gain_ff,// front amp gain
   output logic [1:0]                        filter_gain_ff,   // filter gain
   output logic [1:0]                        front_amp_bias_ff,// front amp bias
   output logic [1:0]                        if_bandwidth_select_ff, // bandwidth select
   output logic [6:0]                        rssi_code_ff,     // strength code 0..80
   output logic                              rssi_valid_ff     // code is settled
);

   localparam int SW  = imrcal_pkg::SAMPLE_W;
   localparam int ACW = SW - 1 + AVG_LOG2;

   // ********************************************************
   // registers
   // ********************************************************
   logic [31:0] trim_reg_ff;
   logic [31:0] gain_reg_ff;
   logic [31:0] clk_reg_ff;
   logic [31:0] demod_reg_ff;
   logic        tone_half_ff;
   logic        wr_trim;
   logic        wr_gain;
   logic        wr_clk;
   logic        wr_demod;
   logic        wr_tone;

   assign wr_trim  = reg_wr && (reg_addr == imrcal_pkg::OFS_TRIM);
   assign wr_gain  = reg_wr && (reg_addr == imrcal_pkg::OFS_GAIN);
   assign wr_clk   = reg_wr && (reg_addr == imrcal_pkg::OFS_CLK);
   assign wr_demod = reg_wr && (reg_addr == imrcal_pkg::OFS_DEMOD);
   assign wr_tone  = reg_wr && (reg_addr == imrcal_pkg::OFS_TONE);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trim_reg_ff  <= imrcal_pkg::RST_TRIM;
         gain_reg_ff  <= imrcal_pkg::RST_GAIN;
         clk_reg_ff   <= imrcal_pkg::RST_CLK;
         demod_reg_ff <= imrcal_pkg::RST_DEMOD;
         tone_half_ff <= imrcal_pkg::RST_HALF;
      end else begin
         if (wr_trim) begin
            trim_reg_ff <= reg_wdata;
         end
         if (wr_gain) begin
            gain_reg_ff <= reg_wdata;
         end
         if (wr_clk) begin
            clk_reg_ff <= reg_wdata;
         end
         if (wr_demod) begin
            demod_reg_ff <= reg_wdata;
         end
         if (wr_tone) begin
            tone_half_ff <= reg_wdata[imrcal_pkg::TONE_HALF_BIT];
         end
      end
   end

   // ********************************************************
   // register read: setup registers are write only, except the tone halving bit
   // ********************************************************
   logic [31:0] nxt_rdata;

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      if (reg_addr == imrcal_pkg::OFS_RSSI) begin
         nxt_rdata[6:0] = rssi_code_ff;
         nxt_rdata[imrcal_pkg::RSSI_VALID_BIT] = rssi_valid_ff;
      end else if (reg_addr == imrcal_pkg::OFS_TONE) begin
         nxt_rdata[imrcal_pkg::TONE_HALF_BIT] = tone_half_ff;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata_ff <= nxt_rdata;
      end else begin
         reg_rdata_ff <= 32'h0000_0000;
      end
   end

   // ********************************************************
   // field outputs
   // ********************************************************
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         gain_ctl_sel_ff   <= 2'h0;
         front_amp_gain_ff <= 2'h0;
         filter_gain_ff    <= 2'h0;
         front_amp_bias_ff <= 2'h0;
         if_bandwidth_select_ff <= 2'h0;
      end else begin
         gain_ctl_sel_ff   <= gain_reg_ff[imrcal_pkg::GSEL_LSB +: 2];
         front_amp_gain_ff <= gain_reg_ff[imrcal_pkg::FAMP_GAIN_LSB +: 2];
         filter_gain_ff    <= gain_reg_ff[imrcal_pkg::FILT_GAIN_LSB +: 2];
         front_amp_bias_ff <= gain_reg_ff[imrcal_pkg::FAMP_BIAS_LSB +: 2];
         if_bandwidth_select_ff <= demod_reg_ff[imrcal_pkg::BW_LSB +: 2];
      end
   end

   // coarse calibration runs once per trim write with the bit set
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         coarse_cal_ff <= 1'b0;
      end else begin
         coarse_cal_ff <= wr_trim && reg_wdata[imrcal_pkg::TRIM_COARSE_BIT];
      end
   end

   // ********************************************************
   // tone base clock divider
   // ********************************************************
   logic [3:0] div_cnt_ff;
   logic       half_phase_ff;
   logic [3:0] div_val;
   logic       base_tick;

   // divider of zero behaves as one, no stall
   assign div_val   = (clk_reg_ff[imrcal_pkg::DIV_LSB +: 4] == 4'h0) ? 4'h1
                    : clk_reg_ff[imrcal_pkg::DIV_LSB +: 4];
   assign base_tick = (div_cnt_ff >= 4'(div_val - 4'h1));

   always_ff @(posedge clk) begin
      if (sys_rst || wr_clk) begin
         div_cnt_ff    <= 4'h0;
         half_phase_ff <= 1'b0;
      end else begin
         div_cnt_ff <= base_tick ? 4'h0 : 4'(div_cnt_ff + 4'h1);
         if (base_tick) begin
            half_phase_ff <= ~half_phase_ff;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tone_tick_ff <= 1'b0;
      end else begin
         // halving drops every other base tick
         tone_tick_ff <= base_tick && (!tone_half_ff || half_phase_ff);
      end
   end

   // ********************************************************
   // trim decode and iq correction
   // ********************************************************
   imrcal_pkg::imrcal_trim_s trim;

   always_comb begin
      trim.gain_atten  = trim_reg_ff[imrcal_pkg::TRIM_POL_BIT];
      trim.gain_on_q   = trim_reg_ff[imrcal_pkg::TRIM_GSIDE_BIT];
      trim.gain_level  = trim_reg_ff[imrcal_pkg::TRIM_GLVL_LSB +: 5];
      trim.phase_on_q  = trim_reg_ff[imrcal_pkg::TRIM_PSIDE_BIT];
      trim.phase_level = trim_reg_ff[imrcal_pkg::TRIM_PLVL_LSB +: 4];
   end

   imrcal_iq_trim u_iq_trim (
      .clk          (clk),
      .sys_rst      (sys_rst),
      .trim         (trim),
      .in_iq        (adc_iq),
      .in_valid     (adc_valid),
      .out_iq_ff    (trim_iq_ff),
      .out_valid_ff (trim_valid_ff)
   );

   // ********************************************************
   // signal strength measurement
   // ********************************************************
   function automatic logic [SW-2:0] mag(input logic signed [SW-1:0] x);
      logic [SW-1:0] a;
      a = x[SW-1] ? SW'(-x) : SW'(x);
      // most negative code saturates rather than wrapping to zero
      return a[SW-1] ? {(SW-1){1'b1}} : a[SW-2:0];
   endfunction

   logic [SW-2:0]     mag_i;
   logic [SW-2:0]     mag_q;
   logic [SW-2:0]     peak;
   logic [ACW-1:0]    acc_ff;
   logic [AVG_LOG2:0] cnt_ff;
   logic [ACW-1:0]    acc_sum;
   logic              win_done;
   logic [SW-2:0]     avg;
   logic [6:0]        nxt_code;

   assign mag_i    = mag(trim_iq_ff.i);
   assign mag_q    = mag(trim_iq_ff.q);
   assign peak     = (mag_i > mag_q) ? mag_i : mag_q;
   assign acc_sum  = ACW'(acc_ff + {{AVG_LOG2{1'b0}}, peak});
   assign win_done = trim_valid_ff && (cnt_ff == (AVG_LOG2+1)'((1 << AVG_LOG2) - 1));
   assign avg      = acc_sum[ACW-1:AVG_LOG2];
   // top seven magnitude bits, clipped to the full-scale code
   assign nxt_code = (avg[SW-2 -: 7] > imrcal_pkg::RSSI_MAX) ? imrcal_pkg::RSSI_MAX
                   : avg[SW-2 -: 7];

   // window restarts on a trim write; a sample trimmed at the write edge still enters with old settings
   always_ff @(posedge clk) begin
      if (sys_rst || wr_trim) begin
         acc_ff <= '0;
         cnt_ff <= '0;
      end else if (win_done) begin
         acc_ff <= '0;
         cnt_ff <= '0;
      end else if (trim_valid_ff) begin
         acc_ff <= acc_sum;
         cnt_ff <= (AVG_LOG2+1)'(cnt_ff + 1'b1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rssi_code_ff <= 7'h00;
      end else if (win_done && !wr_trim) begin
         rssi_code_ff <= nxt_code;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || wr_trim) begin
         rssi_valid_ff <= 1'b0;
      end else if (win_done) begin
         rssi_valid_ff <= 1'b1;
      end
   end

endmodule // imrcal_top

// file: verif/imrcal_props.sv
`timescale 1ns/1ns
// ****************************************
// bus, field and strength checks
// ****************************************
module imrcal_props #(
   parameter int AVG_LOG2 = 6                       // strength window log2
) (
   input wire logic                          clk,               // clock
   input wire logic                          sys_rst,           // reset
   input wire logic [imrcal_pkg::ADDR_W-1:0] reg_addr,          // address
   input wire logic [31:0]                   reg_wdata,         // write data
   input wire logic                          reg_wr,            // write strobe
   input wire logic                          reg_rd,            // read strobe
   input wire logic [31:0]                   reg_rdata_ff,      // read data
   input wire logic                          adc_valid,         // sample in
   input wire logic                          trim_valid_ff,     // sample out
   input wire logic                          tone_tick_ff,      // tone pulse
   input wire logic                          coarse_cal_ff,     // cal pulse
   input wire logic [1:0]                    gain_ctl_sel_ff,   // gain select
   input wire logic [1:0]                    front_amp_bias_ff, // amp bias
   input wire logic [1:0]                    if_bandwidth_select_ff, // bandwidth
   input wire logic [6:0]                    rssi_code_ff,      // strength
   input wire logic                          rssi_valid_ff      // settled
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   logic wr_trim;
   assign wr_trim = reg_wr && reg_addr == imrcal_pkg::OFS_TRIM;
   property p_gsel;
      reg_wr && reg_addr == imrcal_pkg::OFS_GAIN |-> ##2 gain_ctl_sel_ff == $past(reg_wdata[19:18], 2);
   endproperty
   a_gsel: assert property (p_gsel) else $error("gain select not taken");
   property p_bias;
      reg_wr && reg_addr == imrcal_pkg::OFS_GAIN |-> ##2 front_amp_bias_ff == $past(reg_wdata[27:26], 2);
   endproperty
   a_bias: assert property (p_bias) else $error("amp bias not taken");
   property p_bw;
      reg_wr && reg_addr == imrcal_pkg::OFS_DEMOD |->
         ##2 if_bandwidth_select_ff == $past(reg_wdata[31:30], 2);
   endproperty
   a_bw: assert property (p_bw) else $error("bandwidth not taken");
   property p_coarse;
      coarse_cal_ff == $past(wr_trim && reg_wdata[4]);
   endproperty
   a_coarse: assert property (p_coarse) else $error("coarse pulse wrong");
   property p_max;
      rssi_code_ff <= imrcal_pkg::RSSI_MAX;
   endproperty
   a_max: assert property (p_max) else $error("strength above range");
   property p_idle;
      !$past(reg_rd) |-> reg_rdata_ff == 32'h0000_0000;
   endproperty
   a_idle: assert property (p_idle) else $error("read data outside slot");
   property p_clr;
      wr_trim |=> !rssi_valid_ff;
   endproperty
   a_clr: assert property (p_clr) else $error("valid kept over trim write");
   property p_pipe;
      trim_valid_ff == $past(adc_valid);
   endproperty
   a_pipe: assert property (p_pipe) else $error("sample strobe delay");
   property p_win;
      $rose(rssi_valid_ff) |-> $past(trim_valid_ff) && !$past(wr_trim);
   endproperty
   a_win: assert property (p_win) else $error("window end without sample");
   c_win: cover property ($rose(rssi_valid_ff));
   c_cal: cover property (coarse_cal_ff);
   c_tone: cover property (tone_tick_ff ##1 !tone_tick_ff);
endmodule // imrcal_props

bind imrcal_top imrcal_props #(.AVG_LOG2(AVG_LOG2)) i_imrcal_props (
   .clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_ff,
   .adc_valid, .trim_valid_ff, .tone_tick_ff, .coarse_cal_ff, .gain_ctl_sel_ff,
   .front_amp_bias_ff, .if_bandwidth_select_ff, .rssi_code_ff, .rssi_valid_ff
);

// file: verif/imrcal_src.sv
`timescale 1ns/1ns
// ****************************************
// mixer sample source
// ****************************************
module imrcal_src (
   input  wire logic               clk,       // clock
   input  wire logic               sys_rst,   // reset
   input  wire logic               req,       // start burst
   input  wire logic [3:0]         n,         // samples in burst
   input  wire logic signed [11:0] amp,       // value for i and q
   output imrcal_pkg::imrcal_iq_s  adc_iq,    // samples
   output logic                    adc_valid, // strobe
   output logic                    busy       // burst running
);
   logic [3:0] left_ff;
   logic       gap_ff;
   assign busy = left_ff != 4'h0;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         left_ff <= 4'h0;
         gap_ff <= 1'b0;
         adc_valid <= 1'b0;
         adc_iq <= '0;
      end else if (req) begin
         left_ff <= n;
         gap_ff <= 1'b0;
      end else if (busy && !gap_ff) begin
         adc_iq <= {amp, amp};
         adc_valid <= 1'b1;
         left_ff <= left_ff - 4'h1;
         gap_ff <= 1'b1;
      end else begin
         // off-strobe lines toggle so a stale sample is never reused
         adc_iq <= ~adc_iq;
         adc_valid <= 1'b0;
         gap_ff <= 1'b0;
      end
   end
endmodule // imrcal_src

// file: verif/imrcal_tb_top.sv
`timescale 1ns/1ns
module imrcal_tb_top;
   logic                   clk, sys_rst, reg_wr, reg_rd, req, busy, adc_valid;
   logic [7:0]             reg_addr;
   logic [31:0]            reg_wdata, reg_rdata_ff, d;
   logic [3:0]             n;
   logic [4:0]             p;
   logic signed [11:0]     amp;
   imrcal_pkg::imrcal_iq_s adc_iq, trim_iq_ff;
   logic                   trim_valid_ff, tone_tick_ff, coarse_cal_ff, rssi_valid_ff;
   logic [1:0]             gsel, fgain, filt, bias, bw;
   logic [6:0]             code, mn;
   int                     miscompares, n_compared, cyc;
   imrcal_top #(.AVG_LOG2(2)) i_imrcal_top (.clk, .sys_rst, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata_ff, .adc_iq, .adc_valid, .trim_iq_ff,
      .trim_valid_ff, .tone_tick_ff, .coarse_cal_ff, .gain_ctl_sel_ff(gsel),
      .front_amp_gain_ff(fgain), .filter_gain_ff(filt), .front_amp_bias_ff(bias),
      .if_bandwidth_select_ff(bw), .rssi_code_ff(code), .rssi_valid_ff);
   imrcal_src i_imrcal_src (.clk, .sys_rst, .req, .n, .amp, .adc_iq, .adc_valid, .busy);
   always #4 clk = ~clk;
   // ****************************************
   // bus and compare tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= w;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata_ff;
   endtask
   task automatic send(input logic [3:0] k, input logic signed [11:0] v);
      @(posedge clk);
      req <= 1'b1;
      n <= k;
      amp <= v;
      @(posedge clk);
      req <= 1'b0;
      repeat (40) begin
         @(posedge clk);
         #1 if (busy === 1'b0) break;
      end
      repeat (3) @(posedge clk);
   endtask
   // controller's own index map: sign picks side, size picks level
   function automatic logic [4:0] pmap(input int idx);
      return {idx < 0, 4'(idx < 0 ? -idx : idx)};
   endfunction
   task automatic run_iq(input logic [31:0] w, input logic [11:0] xi, xq);
      wr(imrcal_pkg::OFS_TRIM, w);
      send(4'h1, 12'sh100);
      chk("trim_i", {20'h0, xi}, {20'h0, trim_iq_ff.i});
      chk("trim_q", {20'h0, xq}, {20'h0, trim_iq_ff.q});
   endtask
   task automatic tcount(input logic [31:0] e);
      logic [31:0] c;
      c = 0;
      repeat (12) @(posedge clk);
      repeat (40) begin
         @(posedge clk);
         #1 c = c + tone_tick_ff;
      end
      chk("tone_ticks", e, c);
   endtask
   task automatic summarize;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         miscompares++;
         summarize();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      clk = 0;
      sys_rst = 1;
      {reg_wr, reg_rd, req, reg_addr, reg_wdata, n, amp} = '0;
      miscompares = 0;
      n_compared = 0;
      cyc = 0;
      repeat (20) @(posedge clk);
      sys_rst <= 1'b0;
      wr(imrcal_pkg::OFS_GAIN, 32'h0c84_0000);
      @(posedge clk);
      #1 chk("fields", 32'h0000_004b, {24'h0, gsel, fgain, filt, bias});
      wr(imrcal_pkg::OFS_DEMOD, 32'h8000_0000);
      @(posedge clk);
      #1 chk("bw", 32'h0000_0002, {30'h0, bw});
      wr(imrcal_pkg::OFS_TRIM, 32'h8000_0010);
      // pulse stands only in the cycle right after the write edge
      #1 chk("coarse_on", 32'h1, {31'h0, coarse_cal_ff});
      @(posedge clk);
      #1 chk("coarse_off", 32'h0, {31'h0, coarse_cal_ff});
      for (int a = 0; a < 5; a++) begin
         rd(a == 4 ? 8'h20 : 8'(a * 4));
         chk("refused_read", 32'h0, d);
      end
      run_iq({1'b1, 1'b1, 5'h18, 5'h00, 20'h0}, 12'h100, 12'h100 * 24 / 32);
      run_iq({1'b0, 1'b0, 5'h08, 5'h00, 20'h0}, 12'h100 * 40 / 32, 12'h100);
      run_iq({2'b10, 5'h00, pmap(4), 20'h0}, 12'h100 + 12'h100 * 4 / 64, 12'h100);
      run_iq({2'b10, 5'h00, pmap(-4), 20'h0}, 12'h100, 12'h100 + 12'h100 * 4 / 64);
      wr(imrcal_pkg::OFS_TRIM, 32'h8000_0000);
      send(4'h4, 12'sh400);
      rd(imrcal_pkg::OFS_RSSI);
      chk("rssi_mid", 32'h0000_0140, d);
      send(4'h4, 12'sh800);
      rd(imrcal_pkg::OFS_RSSI);
      chk("rssi_clip", 32'h0000_0150, d);
      wr(imrcal_pkg::OFS_TRIM, 32'h8000_0000);
      rd(imrcal_pkg::OFS_RSSI);
      chk("rssi_cleared", 32'h0, {31'h0, d[8]});
      // tone check at both trim extremes, attenuation only, keep the lowest
      mn = 7'h7f;
      for (int s = -15; s <= 15; s += 30) begin
         p = pmap(s);
         wr(imrcal_pkg::OFS_TRIM, {1'b1, p[4], 1'b0, p[3:0], p, 20'h0});
         send(4'h4, 12'sh400);
         rd(imrcal_pkg::OFS_RSSI);
         // untrimmed side keeps the peak, so both extremes read mid scale
         chk("rssi_extreme", 32'h0000_0140, d);
         chk("tone_usable", 32'h1, {31'h0, (d[6:0] >= 7'h3c) && (d[6:0] <= 7'h50)});
         if (d[6:0] < mn) mn = d[6:0];
      end
      chk("sweep_min", 32'h0000_0040, {25'h0, mn});
      // harmonic choice and receive operation live on the radio side
      wr(imrcal_pkg::OFS_CLK, 32'h0000_0080);
      wr(imrcal_pkg::OFS_TONE, 32'h0);
      tcount(32'd20);
      wr(imrcal_pkg::OFS_CLK, 32'h0000_0140);
      tcount(32'd8);
      wr(imrcal_pkg::OFS_TONE, 32'h1);
      tcount(32'd4);
      rd(imrcal_pkg::OFS_TONE);
      chk("tone_half", 32'h1, d);
      summarize();
   end
endmodule // imrcal_tb_top
